// [rtl/qdsp_defines.vh]
// Constants for the quad DAC serial input port
`ifndef QDSP_DEFINES_VH
`define QDSP_DEFINES_VH
`define QDSP_FRAME_BITS 24
`define QDSP_CTRL_BITS 8
`define QDSP_DATA_BITS 16
`define QDSP_ADDR_HI_POS 23
`define QDSP_ADDR_LO_POS 22
`define QDSP_LDSEL_HI_POS 21
`define QDSP_LDSEL_LO_POS 20
`define QDSP_CHSEL_HI_POS 18
`define QDSP_CHSEL_LO_POS 17
`define QDSP_PD_POS 16
`define QDSP_CNT_W 5
`define QDSP_SHIFT_RST 24'h000000
`define QDSP_WORD_RST 17'h00000
`define QDSP_CNT_RST 5'h00
`define QDSP_DAC_RST 16'h0000
`define QDSP_PD_RST 4'h0
`define QDSP_LINK_SYNC_RST 3'h6
`define QDSP_CTRL_SYNC_RST 4'h4
`define QDSP_SCLK_PREV_RST 1'h1
`define QDSP_LD_PREV_RST 1'h0
`endif

// [rtl/qdsp_port.v]
// Serial input port of a quad 16-bit DAC, sampled on the core clock
`timescale 1ns/1ps
`include "qdsp_defines.vh"
module qdsp_port #(
  parameter FRAME_BITS = 24,
  parameter DATA_BITS = 16
) (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_sync_n,
  input wire i_sclk,
  input wire i_sdata,
  input wire i_enable_n,
  input wire i_addr_pin_low,
  input wire i_addr_pin_high,
  input wire i_load_all_strobe,
  output reg [DATA_BITS-1:0] o_dac_a_ff,
  output reg [DATA_BITS-1:0] o_dac_b_ff,
  output reg [DATA_BITS-1:0] o_dac_c_ff,
  output reg [DATA_BITS-1:0] o_dac_d_ff,
  output reg [3:0] o_pd_ff,
  output reg o_frame_done_ff,
  output reg [FRAME_BITS-1:0] o_frame_word_ff
);

  // Link pins share one delay so each data bit lines up with its clock
  wire [2:0] link_sync;
  wire [3:0] ctrl_sync;
  qdsp_sync2 #(
    .WIDTH(3),
    .RST_VAL(`QDSP_LINK_SYNC_RST)
  ) i_link_sync (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_sync_n, i_sclk, i_sdata}),
    .o_sync_ff(link_sync)
  );
  // Address pins are static, but still cross domains at power-up
  qdsp_sync2 #(
    .WIDTH(4),
    .RST_VAL(`QDSP_CTRL_SYNC_RST)
  ) i_ctrl_sync (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_load_all_strobe, i_enable_n, i_addr_pin_high, i_addr_pin_low}),
    .o_sync_ff(ctrl_sync)
  );

  wire sync_n = link_sync[2];
  wire sclk_s = link_sync[1];
  wire din_s = link_sync[0];
  wire ld_s = ctrl_sync[3];
  wire enable_n = ctrl_sync[2];
  wire [1:0] addr_s = ctrl_sync[1:0];

  // Edge history resets to idle pin levels, so reset makes no false edge
  reg sclk_prev_ff;
  reg ld_prev_ff;
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_prev_ff <= `QDSP_SCLK_PREV_RST;
      ld_prev_ff <= `QDSP_LD_PREV_RST;
    end else begin
      sclk_prev_ff <= sclk_s;
      ld_prev_ff <= ld_s;
    end
  end

  wire sclk_fall = sclk_prev_ff & ~sclk_s;
  wire ld_rise = ~ld_prev_ff & ld_s;
  wire port_on = ~enable_n;

  reg [FRAME_BITS-1:0] shift_ff;
  reg [`QDSP_CNT_W-1:0] cnt_ff;
  reg locked_ff;
  wire [FRAME_BITS-1:0] nxt_shift = {shift_ff[FRAME_BITS-2:0], din_s};
  wire last_bit = (cnt_ff == FRAME_BITS - 1);

  // Temporary (stored) registers, DAC registers are the outputs
  reg [DATA_BITS:0] tmp_ff [0:3];
  reg decode_ff;
  integer k;

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift_ff <= `QDSP_SHIFT_RST;
      cnt_ff <= `QDSP_CNT_RST;
      locked_ff <= 1'b0;
      decode_ff <= 1'b0;
      o_frame_done_ff <= 1'b0;
      o_frame_word_ff <= `QDSP_SHIFT_RST;
    end else begin
      decode_ff <= 1'b0;
      o_frame_done_ff <= 1'b0;
      if (!port_on || sync_n) begin
        // Idle or aborted: early rise drops the partial frame
        cnt_ff <= `QDSP_CNT_RST;
        locked_ff <= 1'b0;
      end else if (sclk_fall && !locked_ff) begin
        shift_ff <= nxt_shift;
        cnt_ff <= cnt_ff + 1'b1;
        if (last_bit) begin
          locked_ff <= 1'b1;
          decode_ff <= 1'b1;
          o_frame_done_ff <= 1'b1;
          o_frame_word_ff <= nxt_shift;
        end
      end
    end
  end

  // Frame decode: address match, load-select, channel, data or power-down
  wire [1:0] ldsel = {shift_ff[`QDSP_LDSEL_HI_POS], shift_ff[`QDSP_LDSEL_LO_POS]};
  wire [1:0] chsel = {shift_ff[`QDSP_CHSEL_HI_POS], shift_ff[`QDSP_CHSEL_LO_POS]};
  wire [DATA_BITS:0] payload = {shift_ff[`QDSP_PD_POS], shift_ff[DATA_BITS-1:0]};
  wire addr_ok = (shift_ff[`QDSP_ADDR_HI_POS] == addr_s[1]) &&
                 (shift_ff[`QDSP_ADDR_LO_POS] == addr_s[0]);
  wire bcast = (ldsel == 2'h3);
  wire act = decode_ff && port_on && (addr_ok || bcast);

  reg [DATA_BITS:0] dac_ff [0:3];
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (k = 0; k < 4; k = k + 1) begin
        tmp_ff[k] <= `QDSP_WORD_RST;
        dac_ff[k] <= `QDSP_WORD_RST;
      end
    end else if (port_on) begin
      if (act) begin
        case (ldsel)
          2'h0: tmp_ff[chsel] <= payload;
          2'h1: begin
            tmp_ff[chsel] <= payload;
            dac_ff[chsel] <= payload;
          end
          2'h2: begin
            for (k = 0; k < 4; k = k + 1) begin
              dac_ff[k] <= (k == chsel) ? payload : tmp_ff[k];
            end
            tmp_ff[chsel] <= payload;
          end
          default: begin
            // Broadcast: channel-select high bit picks fresh data or stored
            for (k = 0; k < 4; k = k + 1) begin
              if (chsel[1]) begin
                tmp_ff[k] <= payload;
                dac_ff[k] <= payload;
              end else begin
                dac_ff[k] <= tmp_ff[k];
              end
            end
          end
        endcase
      end else if (ld_rise) begin
        // A strobe in a decode cycle with address match or broadcast is dropped; the serial update wins
        for (k = 0; k < 4; k = k + 1) begin
          dac_ff[k] <= tmp_ff[k];
        end
      end
    end
  end

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dac_a_ff <= `QDSP_DAC_RST;
      o_dac_b_ff <= `QDSP_DAC_RST;
      o_dac_c_ff <= `QDSP_DAC_RST;
      o_dac_d_ff <= `QDSP_DAC_RST;
      o_pd_ff <= `QDSP_PD_RST;
    end else begin
      o_dac_a_ff <= dac_ff[0][DATA_BITS-1:0];
      o_dac_b_ff <= dac_ff[1][DATA_BITS-1:0];
      o_dac_c_ff <= dac_ff[2][DATA_BITS-1:0];
      o_dac_d_ff <= dac_ff[3][DATA_BITS-1:0];
      o_pd_ff <= {dac_ff[3][DATA_BITS], dac_ff[2][DATA_BITS],
                  dac_ff[1][DATA_BITS], dac_ff[0][DATA_BITS]};
    end
  end

  // Host spacing limits are the host's duty; nothing here polices them

endmodule

// Two-flop synchroniser for pins from outside the core clock's domain
module qdsp_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync_ff
);

  // Only the second flop is read; the first may be metastable
  reg [WIDTH-1:0] meta_ff;
  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_ff <= RST_VAL;
      o_sync_ff <= RST_VAL;
    end else begin
      meta_ff <= i_async;
      o_sync_ff <= meta_ff;
    end
  end

endmodule

// [verif/qdsp_host_model.sv]
// Host serial master model
`timescale 1ns/1ps
module qdsp_host_model (
  output logic o_sync_n,
  output logic o_sclk,
  output logic o_sdata
);
  // Clock idles high and stands still between frames
  initial {o_sync_n, o_sclk, o_sdata} = 3'h6;
  task send(input logic [23:0] w, input int n);
    o_sync_n = 0;
    #160;
    for (int i = 0; i < n; i++) begin
      o_sdata = w[23-i];
      #160 o_sclk = 0;
      #160 o_sclk = 1;
    end
    #320 o_sync_n = 1;
    o_sdata = ~o_sdata;
    #320;
  endtask
endmodule

// [verif/qdsp_port_checker.sv]
// Checker on the serial port pins
`timescale 1ns/1ps
module qdsp_port_checker #(parameter FRAME_BITS = 24, DATA_BITS = 16) (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_sync_n,
  input wire i_enable_n,
  input wire i_addr_pin_low,
  input wire i_addr_pin_high,
  input wire i_load_all_strobe,
  input wire [DATA_BITS-1:0] o_dac_a_ff,
  input wire [DATA_BITS-1:0] o_dac_d_ff,
  input wire o_frame_done_ff,
  input wire [FRAME_BITS-1:0] o_frame_word_ff
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  wire go = o_frame_done_ff;
  wire hit = o_frame_word_ff[23:22] == {i_addr_pin_high, i_addr_pin_low};
  wire [4:0] cmd = {o_frame_word_ff[21:20], o_frame_word_ff[18:16]};
  wire [15:0] dat = o_frame_word_ff[15:0];
  chk_done_pulse: assert property (go |=> !go [*8]) else $error("done too long");
  chk_word_lock: assert property (go |=> $stable(o_frame_word_ff) [*8]) else $error("word");
  chk_word_cause: assert property ($changed(o_frame_word_ff) |-> go || $past(go)) else $error("wc");
  chk_sync_frame: assert property (go |-> !$past(i_sync_n, 6)) else $error("no frame");
  chk_enable_freeze: assert property (i_enable_n [*6] |=> !go && $stable(o_dac_a_ff))
    else $error("active while off");
  chk_addr_skip: assert property (go && !hit && cmd[4:3] != 2'h3 |-> ##2 $stable(o_dac_a_ff))
    else $error("not addressed");
  chk_single_load: assert property (go && hit && cmd == 5'h08 |-> ##2 o_dac_a_ff == dat)
    else $error("update lost");
  chk_broadcast_all: assert property (go && cmd[4:2] == 3'h7 && !cmd[0] |-> ##2 o_dac_d_ff == dat)
    else $error("broadcast lost");
  chk_dac_cause: assert property ($changed(o_dac_a_ff) |-> $past(go, 2) || $past(i_load_all_strobe))
    else $error("dac change");
  cover property (go && hit);
  cover property (go && !hit);
  cover property ($rose(i_load_all_strobe) && !i_enable_n);
endmodule
bind qdsp_port qdsp_port_checker #(
  .FRAME_BITS(FRAME_BITS),
  .DATA_BITS(DATA_BITS)
) i_chk (
  .i_core_clk(i_core_clk),
  .i_sys_rst(i_sys_rst),
  .i_sync_n(i_sync_n),
  .i_enable_n(i_enable_n),
  .i_addr_pin_low(i_addr_pin_low),
  .i_addr_pin_high(i_addr_pin_high),
  .i_load_all_strobe(i_load_all_strobe),
  .o_dac_a_ff(o_dac_a_ff),
  .o_dac_d_ff(o_dac_d_ff),
  .o_frame_done_ff(o_frame_done_ff),
  .o_frame_word_ff(o_frame_word_ff)
);

// [verif/tb_quad_dac_serial_input_port.sv]
// Self-checking bench for the quad DAC serial port
`timescale 1ns/1ps
module tb_quad_dac_serial_input_port;
  logic clk = 0, rst = 1, en_n = 0, ld = 0;
  logic [1:0] adr = 0;
  logic [23:0] w, last = 0;
  wire sync_n, sclk, sdata, done;
  wire [3:0] pd;
  wire [23:0] word;
  wire [3:0][15:0] dac;
  int err_count = 0, check_count = 0, n, ch, c, v, tmp[4], mdl[4];
  int done_seen = 0, done_exp = 0;
  always #20 clk = ~clk;
  // Counted on the falling edge, clear of the edge that launches the pulse
  always @(negedge clk) if (done === 1'b1) done_seen++;
  qdsp_host_model i_host(.o_sync_n(sync_n), .o_sclk(sclk), .o_sdata(sdata));
  qdsp_port i_dut(.i_core_clk(clk), .i_sys_rst(rst), .i_sync_n(sync_n), .i_sclk(sclk),
    .i_sdata(sdata), .i_enable_n(en_n), .i_addr_pin_low(adr[0]), .i_addr_pin_high(adr[1]),
    .i_load_all_strobe(ld), .o_dac_a_ff(dac[0]), .o_dac_b_ff(dac[1]), .o_dac_c_ff(dac[2]),
    .o_dac_d_ff(dac[3]), .o_pd_ff(pd), .o_frame_done_ff(done), .o_frame_word_ff(word));
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #3000000 err_count++;
    end_sim;
  end
  initial begin
    void'($urandom(82));
    repeat (12) @(posedge clk);
    #1 rst = 0;
    repeat (4) @(posedge clk);
    for (int t = 0; t < 60; t++) begin
      w = 24'($urandom);
      n = ($urandom % 5 == 0) ? 1 + $urandom % 23 : 24;
      @(posedge clk) #1 en_n = (t > 1) && ($urandom % 6 == 0);
      adr = 2'($urandom);
      if ($urandom % 3) w[23:22] = adr;
      // First two frames: single update of channel A, then broadcast of fresh data
      if (t < 2) begin
        w[21:16] = (t == 0) ? 6'h10 : 6'h34;
        w[23:22] = adr;
        n = 24;
      end
      i_host.send(w, n);
      ch = w[18:17];
      v = w[16:0];
      // Short or disabled frames must leave every register alone
      if (!en_n && n == 24) begin
        last = w;
        done_exp++;
        if (w[23:22] == adr || w[21:20] == 2'h3)
          case (w[21:20])
            0: tmp[ch] = v;
            1: begin tmp[ch] = v; mdl[ch] = v; end
            2: begin tmp[ch] = v; mdl = tmp; end
            3: begin if (w[18]) tmp = '{v, v, v, v}; mdl = tmp; end
          endcase
      end
      if ($urandom % 4 == 0) begin
        @(posedge clk) #1 ld = 1;
        repeat (10) @(posedge clk);
        #1 ld = 0;
        if (!en_n) mdl = tmp;
      end
      repeat (4) @(negedge clk);
      for (c = 0; c < 4; c++) chk("dac", 24'(mdl[c][15:0]), 24'(dac[c]));
      chk("word", last, word);
      chk("pd", 24'({mdl[3][16], mdl[2][16], mdl[1][16], mdl[0][16]}), 24'(pd));
      chk("done", 24'(done_exp), 24'(done_seen));
      $display("test %0d ended", t);
    end
    end_sim;
  end
endmodule
